// [core/ao_engine.sv]
/*
 * Analog output waveform engine: APB register file, update clock
 * generation, start/pause triggering, sample queue drain into a pair of
 * converters, and pin routing of the update clock.
 * Assumes asynchronous pins and trigger lines, a DMA source on the same
 * clock with valid/ready, and converters that latch on UPDATE_STB.
 */
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - each clocked update pops one queued sample; software updates do not
// - one update clock refreshes both channels
// - rising or falling update edge selectable
// - default update clock divides the timebase
// - external clock from pins or lines 0-6
// - software mode: one update per command
// - finite mode stops after programmed count
// - continuous mode runs until stop or underflow
// - standard regen refilled by host transfers
// - queue-only regen replays loaded queue
// - no replay; empty queue flags underflow
// - DMA blocks fill queue, drained per update
// - single host writes enter the queue, except while queue-only regen is not idle
// - start and pause hardware triggers only
// - function pins are inputs after reset
// - pause level suppresses the next samples
// - start launches counter, delay default two
// - routed update clock is active low
module ao_engine
  import ao_pkg::*;
#(
  parameter int QDEPTH = 256,
  parameter int SLOW_DIV = SLOW_TB_DIV
) (
  input  wire logic                CORE_CLK,
  input  wire logic                ARST_N,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic                DMA_VALID,
  input  wire logic [31:0]         DMA_DATA,
  output logic                     DMA_READY,
  input  wire logic [NUM_PINS-1:0] PFP_IN,
  output logic      [NUM_PINS-1:0] PFP_OUT,
  output logic      [NUM_PINS-1:0] PFP_OE,
  input  wire logic [NUM_TBL-1:0]  TBL_IN,
  output logic      [15:0]         CH0_CODE,
  output logic      [15:0]         CH1_CODE,
  output logic                     UPDATE_STB
);

  localparam int QAW = $clog2(QDEPTH);

  // ----------------------------------------------------------------
  // Source selection helper
  // ----------------------------------------------------------------
  function automatic logic src_pick(input logic [NUM_SRC-1:0] v, input logic [4:0] sel);
    src_pick = (int'(sel) < NUM_SRC) ? v[sel] : 1'b0;
  endfunction : src_pick

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Asynchronous assert, two-flop release
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0]        cfg_q;
  logic [23:0]        div_q;
  logic [15:0]        delay_q;
  logic [23:0]        count_q;
  logic [15:0]        pinoe_q;
  logic [23:0]        done_cnt_q;
  logic               uflow_q;
  logic               done_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;
  eng_state_t         state_q;
  logic [NUM_SRC-1:0] src_lvl;
  logic               clk_prev_q;
  logic               strt_prev_q;
  logic               tb_tick;
  logic [15:0]        slow_cnt_q;
  logic [23:0]        tick_cnt_q;
  logic               uclk_int_q;
  logic               pin_n_q;
  logic               upd_q;
  logic [15:0]        ch0_q;
  logic [15:0]        ch1_q;
  logic               wr_acc;
  logic               setup;
  logic               addr_ok;
  logic               start_cmd;
  logic               stop_cmd;
  logic               clr_cmd;
  logic               sw_upd;
  logic               data_wr;
  logic               uflow_clr;
  logic               upd_src;
  logic               upd_evt;
  logic               clk_lvl;
  logic               strt_lvl;
  logic               strt_evt;
  logic               paused;
  logic               take;
  logic               hit_uflow;
  logic               fin_last;
  logic               q_push;
  logic [31:0]        q_din;
  logic               q_ready;
  logic [31:0]        q_dout;
  logic               q_empty;
  logic               q_full;
  logic [QAW:0]       q_level;
  logic               host_lock;
  tsrc_t              tsrc;
  regen_t             regen;

  assign tsrc  = tsrc_t'(cfg_q[CFG_TSRC_LSB +: 2]);
  assign regen = regen_t'(cfg_q[CFG_REGEN_LSB +: 2]);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; command writes become one-cycle pulses
  assign setup     = PSEL && !PENABLE;
  assign wr_acc    = PSEL && PENABLE && PWRITE;
  assign start_cmd = wr_acc && (PADDR == OFS_CTRL) && PWDATA[CTRL_START];
  assign stop_cmd  = wr_acc && (PADDR == OFS_CTRL) && PWDATA[CTRL_STOP];
  assign clr_cmd   = wr_acc && (PADDR == OFS_CTRL) && PWDATA[CTRL_CLEAR];
  assign sw_upd    = wr_acc && (PADDR == OFS_SWUPD);
  assign data_wr   = wr_acc && (PADDR == OFS_DATA);
  assign uflow_clr = wr_acc && (PADDR == OFS_STAT) && PWDATA[STAT_UFLOW];
  assign PREADY    = 1'b1;
  assign PRDATA    = prdata_q;
  assign PSLVERR   = pslverr_q;

  always_comb begin
    unique case (PADDR)
      OFS_CTRL, OFS_CFG, OFS_DIV, OFS_DELAY, OFS_COUNT, OFS_DATA,
      OFS_SWUPD, OFS_STAT, OFS_PINOE, OFS_DONE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Configuration registers
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q   <= CFG_RST;
      div_q   <= DIV_RST;
      delay_q <= DELAY_RST;
      count_q <= COUNT_RST;
      pinoe_q <= PINOE_RST;
    end else if (wr_acc) begin
      unique case (PADDR)
        OFS_CFG:   cfg_q   <= PWDATA;
        OFS_DIV:   div_q   <= PWDATA[23:0];
        OFS_DELAY: delay_q <= PWDATA[15:0];
        OFS_COUNT: count_q <= PWDATA[23:0];
        OFS_PINOE: pinoe_q <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // Read data captured in the setup cycle, valid in the access cycle
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !addr_ok;
      unique case (PADDR)
        OFS_CFG:   prdata_q <= cfg_q;
        OFS_DIV:   prdata_q <= {8'h00, div_q};
        OFS_DELAY: prdata_q <= {16'h0000, delay_q};
        OFS_COUNT: prdata_q <= {8'h00, count_q};
        OFS_PINOE: prdata_q <= {16'h0000, pinoe_q};
        OFS_DONE:  prdata_q <= {8'h00, done_cnt_q};
        OFS_STAT: begin
          prdata_q                         <= '0;
          prdata_q[STAT_RUN]               <= (state_q != ST_IDLE);
          prdata_q[STAT_EMPTY]             <= q_empty;
          prdata_q[STAT_FULL]              <= q_full;
          prdata_q[STAT_UFLOW]             <= uflow_q;
          prdata_q[STAT_DONE]              <= done_q;
          prdata_q[STAT_LVL_LSB +: QAW+1]  <= q_level;
        end
        default:   prdata_q <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin and trigger-line inputs
  // ----------------------------------------------------------------
  pin_sync #(.W(NUM_SRC)) u_sync (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .d     ({TBL_IN, PFP_IN}),
    .q     (src_lvl)
  );

  assign clk_lvl  = src_pick(src_lvl, cfg_q[CFG_CLK_LSB +: 5]);
  assign strt_lvl = src_pick(src_lvl, cfg_q[CFG_STRT_LSB +: 5]);
  assign paused   = cfg_q[CFG_PAUSE_EN] &&
                    (src_pick(src_lvl, cfg_q[CFG_PAUS_LSB +: 5]) != cfg_q[CFG_PAUSE_LOW]);
  assign strt_evt = cfg_q[CFG_START_FALL] ? (strt_prev_q && !strt_lvl)
                                          : (!strt_prev_q && strt_lvl);

  // ----------------------------------------------------------------
  // Timebase and internal update clock divider
  // ----------------------------------------------------------------
  // Slow timebase tick, or every core cycle for the fast timebase
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_q <= '0;
    end else if (slow_cnt_q == 16'(SLOW_DIV - 1)) begin
      slow_cnt_q <= '0;
    end else begin
      slow_cnt_q <= slow_cnt_q + 1'b1;
    end
  end

  assign tb_tick = cfg_q[CFG_SLOW_TB] ? (slow_cnt_q == 16'(SLOW_DIV - 1)) : 1'b1;

  // Start loads the delay; each terminal count then reloads the divider
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      uclk_int_q <= 1'b0;
    end else if (state_q != ST_RUN) begin
      tick_cnt_q <= (delay_q == '0) ? '0 : {8'h00, delay_q - 1'b1};
      uclk_int_q <= 1'b0;
    end else if (tb_tick) begin
      if (tick_cnt_q == '0) begin
        tick_cnt_q <= (div_q == '0) ? '0 : div_q - 1'b1;
        uclk_int_q <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q - 1'b1;
        uclk_int_q <= 1'b0;
      end
    end
  end

  // Edge history of the selected clock and start sources
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q  <= 1'b0;
      strt_prev_q <= 1'b0;
    end else begin
      clk_prev_q  <= (tsrc == TSRC_EXTERNAL) ? clk_lvl : uclk_int_q;
      strt_prev_q <= strt_lvl;
    end
  end

  // Chosen edge of the update clock, from divider or pin
  always_comb begin
    upd_src = (tsrc == TSRC_EXTERNAL) ? clk_lvl : uclk_int_q;
    upd_evt = 1'b0;
    if (tsrc != TSRC_SOFTWARE) begin
      upd_evt = cfg_q[CFG_FALL] ? (clk_prev_q && !upd_src)
                                : (!clk_prev_q && upd_src);
    end
  end

  // ----------------------------------------------------------------
  // Engine control
  // ----------------------------------------------------------------
  // Pause is sampled at each update edge and suppresses that same update
  assign take      = (state_q == ST_RUN) && upd_evt && !paused && !uflow_q;
  assign hit_uflow = take && q_empty;
  assign fin_last  = cfg_q[CFG_FINITE] && (done_cnt_q + 24'h000001 >= count_q);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (stop_cmd || hit_uflow) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:  if (start_cmd && tsrc != TSRC_SOFTWARE) begin
                    state_q <= cfg_q[CFG_START_HW] ? ST_ARMED : ST_RUN;
                  end
        ST_ARMED: if (strt_evt) begin
                    state_q <= ST_RUN;
                  end
        ST_RUN:   if (take && !q_empty && fin_last) begin
                    state_q <= ST_IDLE;
                  end
      endcase
    end
  end

  // Output count, done flag and sticky underflow; set beats clear
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      done_cnt_q <= '0;
      done_q     <= 1'b0;
      uflow_q    <= 1'b0;
    end else begin
      if (start_cmd && state_q == ST_IDLE) begin
        done_cnt_q <= '0;
        done_q     <= 1'b0;
      end else if (take && !q_empty) begin
        done_cnt_q <= done_cnt_q + 1'b1;
        if (fin_last) begin
          done_q <= 1'b1;
        end
      end
      if (hit_uflow) begin
        uflow_q <= 1'b1;
      end else if (uflow_clr) begin
        uflow_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample queue and its fill sources
  // ----------------------------------------------------------------
  // Queue-only replay pushes each popped word back; host is locked out
  assign host_lock = (regen == REGEN_QUEUE) && (state_q != ST_IDLE);
  assign DMA_READY = q_ready && !host_lock && !data_wr && !take;

  always_comb begin
    q_push = 1'b0;
    q_din  = PWDATA;
    if (take && !q_empty && regen == REGEN_QUEUE) begin
      q_push = 1'b1;
      q_din  = q_dout;
    end else if (data_wr && !host_lock) begin
      q_push = 1'b1;
    end else if (DMA_VALID && DMA_READY) begin
      q_push = 1'b1;
      q_din  = DMA_DATA;
    end
  end

  sample_queue #(.W(32), .DEPTH(QDEPTH)) u_queue (
    .clk      (CORE_CLK),
    .rst_n    (rst_n),
    .clr      (clr_cmd && state_q == ST_IDLE),
    .push     (q_push),
    .din      (q_din),
    .in_ready (q_ready),
    .pop      (take),
    .dout     (q_dout),
    .empty    (q_empty),
    .full     (q_full),
    .level    (q_level)
  );

  // ----------------------------------------------------------------
  // Converter outputs and update clock pin
  // ----------------------------------------------------------------
  // Both channels load together from one word or one command
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ch0_q <= '0;
      ch1_q <= '0;
      upd_q <= 1'b0;
    end else if (sw_upd && tsrc == TSRC_SOFTWARE) begin
      ch0_q <= PWDATA[15:0];
      ch1_q <= PWDATA[31:16];
      upd_q <= 1'b1;
    end else if (take && !q_empty) begin
      ch0_q <= q_dout[15:0];
      ch1_q <= q_dout[31:16];
      upd_q <= 1'b1;
    end else begin
      upd_q <= 1'b0;
    end
  end

  // Update clock leaves the device low-true
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_n_q <= 1'b1;
    end else begin
      pin_n_q <= !((take && !q_empty) || (sw_upd && tsrc == TSRC_SOFTWARE));
    end
  end

  assign CH0_CODE   = ch0_q;
  assign CH1_CODE   = ch1_q;
  assign UPDATE_STB = upd_q;
  assign PFP_OUT    = {NUM_PINS{pin_n_q}};
  assign PFP_OE     = pinoe_q;

endmodule : ao_engine
`default_nettype wire

// [core/ao_pkg.sv]
/*
 * Constants, register map and enumerations for the analog output
 * waveform engine.
 * Assumes a single 25 MHz core clock and 32-bit APB register access.
 */
package ao_pkg;

  // ----------------------------------------------------------------
  // Clock rates and timebase dividers
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 25_000_000;
  localparam int unsigned SLOW_TB_HZ  = 100_000;
  localparam int unsigned SLOW_TB_DIV = CORE_CLK_HZ / SLOW_TB_HZ;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CFG   = 8'h04;
  localparam logic [7:0] OFS_DIV   = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_DATA  = 8'h14;
  localparam logic [7:0] OFS_SWUPD = 8'h18;
  localparam logic [7:0] OFS_STAT  = 8'h1C;
  localparam logic [7:0] OFS_PINOE = 8'h20;
  localparam logic [7:0] OFS_DONE  = 8'h24;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_RST   = 32'h0000_0000;
  localparam logic [23:0] DIV_RST   = 24'h000019;
  localparam logic [15:0] DELAY_RST = 16'h0002;
  localparam logic [23:0] COUNT_RST = 24'h000400;
  localparam logic [15:0] PINOE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START     = 0;
  localparam int CTRL_STOP      = 1;
  localparam int CTRL_CLEAR     = 2;
  localparam int CFG_TSRC_LSB   = 0;
  localparam int CFG_FALL       = 2;
  localparam int CFG_FINITE     = 3;
  localparam int CFG_REGEN_LSB  = 4;
  localparam int CFG_SLOW_TB    = 6;
  localparam int CFG_START_HW   = 7;
  localparam int CFG_START_FALL = 8;
  localparam int CFG_PAUSE_EN   = 9;
  localparam int CFG_PAUSE_LOW  = 10;
  localparam int CFG_CLK_LSB    = 11;
  localparam int CFG_STRT_LSB   = 16;
  localparam int CFG_PAUS_LSB   = 21;
  localparam int STAT_RUN       = 0;
  localparam int STAT_EMPTY     = 1;
  localparam int STAT_FULL      = 2;
  localparam int STAT_UFLOW     = 3;
  localparam int STAT_DONE      = 4;
  localparam int STAT_LVL_LSB   = 8;

  // Source index: 0..15 function pins, 16..22 trigger bus lines 0..6
  localparam int NUM_PINS = 16;
  localparam int NUM_TBL  = 7;
  localparam int NUM_SRC  = NUM_PINS + NUM_TBL;

  typedef enum logic [1:0] {TSRC_INTERNAL, TSRC_EXTERNAL, TSRC_SOFTWARE} tsrc_t;
  typedef enum logic [1:0] {REGEN_STANDARD, REGEN_QUEUE, REGEN_NONE} regen_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} eng_state_t;

endpackage : ao_pkg

// [core/pin_sync.sv]
/*
 * Two-stage synchroniser for a bus of asynchronous pin levels.
 * Assumes each bit is an independent level; no bus coherence.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Two flops; only the second stage is visible outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : pin_sync
`default_nettype wire

// [core/sample_queue.sv]
/*
 * Show-ahead sample queue with empty, full and level status.
 * Assumes the caller pushes only while in_ready is high; a push and a
 * pop in the same cycle are allowed even when full.
 */
`timescale 1ns/1ps
`default_nettype none

module sample_queue #(
  parameter int W     = 32,
  parameter int DEPTH = 256,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic        push,
  input  wire logic [W-1:0] din,
  output logic             in_ready,
  input  wire logic        pop,
  output logic [W-1:0]     dout,
  output logic             empty,
  output logic             full,
  output logic [AW:0]      level
);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          do_pop;

  assign empty    = (cnt_q == '0);
  assign full     = (cnt_q == (AW+1)'(DEPTH));
  assign in_ready = !full || pop;
  assign do_pop   = pop && !empty;
  assign dout     = mem[rd_q];
  assign level    = cnt_q;

  // Storage write
  always_ff @(posedge clk) begin
    if (push && in_ready) begin
      mem[wr_q] <= din;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push && in_ready) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push && in_ready) - (AW+1)'(do_pop);
    end
  end

endmodule : sample_queue
`default_nettype wire

// [test/ao_engine_assertions.sv]
/* Port checker for the waveform engine.
   Assumes it is bound into ao_engine and sees only its top ports. */
`timescale 1ns/1ps
`default_nettype none
module ao_engine_checker
  import ao_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        DMA_READY,
  input wire logic [15:0] PFP_OUT,
  input wire logic [15:0] PFP_OE,
  input wire logic [15:0] CH0_CODE,
  input wire logic [15:0] CH1_CODE,
  input wire logic        UPDATE_STB
);
  // ------------------------------------------------------------
  // Properties on the engine outputs
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  property p_pin;
    PFP_OUT == {16{!UPDATE_STB}};
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin copy of update clock wrong");
  property p_codes;
    !UPDATE_STB |-> $stable(CH0_CODE) && $stable(CH1_CODE);
  endproperty
  a_codes: assert property (p_codes)
    else $error("codes moved without update");
  property p_oe;
    $changed(PFP_OE) |-> $past(PENABLE) || $past(PENABLE, 2);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin enable moved without write");
  property p_dma;
    PSEL && PENABLE && PWRITE && PADDR == OFS_DATA |-> !DMA_READY;
  endproperty
  a_dma: assert property (p_dma)
    else $error("queue taken twice in one cycle");
  property p_err;
    PSEL && PENABLE && PADDR > 8'h24 |-> PSLVERR;
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped access not refused");
  property p_rd0;
    PSEL && !PENABLE && !PWRITE && PADDR > 8'h24 |=> PRDATA == 32'h0000_0000;
  endproperty
  a_rd0: assert property (p_rd0)
    else $error("unmapped read not zero");
  property p_ok;
    PSEL && PENABLE && PADDR == OFS_STAT |-> !PSLVERR;
  endproperty
  a_ok: assert property (p_ok)
    else $error("mapped access refused");
  property p_ready;
    PREADY;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready low");
endmodule : ao_engine_checker
bind ao_engine ao_engine_checker chk_u (.*);
`default_nettype wire

// [test/host_dma.sv]
/* Host DMA source model: sends the words the bench queues.
   Assumes a word is taken at an edge with valid and ready high. */
`timescale 1ns/1ps
`default_nettype none
module host_dma (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        ready,
  output var  logic        valid,
  output var  logic [31:0] data
);
  logic [31:0] q [$];
  // ------------------------------------------------------------
  // Request held until taken; idle data toggles
  // ------------------------------------------------------------
  initial begin
    valid = 1'b0;
    data  = 32'h0000_0000;
    forever @(posedge clk) begin
      if (valid && ready) void'(q.pop_front());
      valid <= (q.size() != 0) && !(slow && valid && ready);
      data  <= (q.size() != 0) ? q[0] : ~data;
    end
  end
endmodule : host_dma
`default_nettype wire

// [test/testbench.sv]
/* Self-checking bench: APB tasks, DMA host model, software,
   finite and underflow runs. Assumes the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ao_pkg::*;
;
  logic        CORE_CLK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic        PWRITE = 1'b0, slow = 1'b0, PREADY, PSLVERR, e;
  logic        DMA_VALID, DMA_READY, UPDATE_STB;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, PRDATA, DMA_DATA, r;
  logic [15:0] PFP_OUT, PFP_OE, CH0_CODE, CH1_CODE, pins = 16'h0000;
  logic [31:0] w [3] = '{32'h1111_AAAA, 32'h2222_BBBB, 32'h3333_CCCC};
  int          bad_count = 0, total_checks = 0, n;
  // ------------------------------------------------------------
  // Clock, design and host model
  // ------------------------------------------------------------
  always #20 CORE_CLK = ~CORE_CLK;
  ao_engine dut_u (.*, .PFP_IN(pins), .TBL_IN(7'h00));
  host_dma host_u (.clk(CORE_CLK), .slow(slow), .ready(DMA_READY),
                   .valid(DMA_VALID), .data(DMA_DATA));
  // APB transfer; result in r and e
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PADDR   <= a;
    PWRITE  <= wr;
    PWDATA  <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  // Wait for an update pulse, counting cycles
  task automatic wstb(output int c);
    c = 0;
    do begin
      @(negedge CORE_CLK);
      c++;
    end while (UPDATE_STB !== 1'b1 && c < 200);
    if (UPDATE_STB !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t no update pulse", $time);
    end
  endtask : wstb
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // ------------------------------------------------------------
  // Test sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    chk({16'h0000, PFP_OE}, 32'h0000_0000);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(r, 32'h0000_0002);
    apb(OFS_DELAY, 1'b0, 32'h0);
    chk(r, {16'h0000, DELAY_RST});
    apb(OFS_DIV, 1'b0, 32'h0);
    chk(r, {8'h00, DIV_RST});
    apb(8'h40, 1'b0, 32'h0);
    chk({r[30:0], e}, 32'h0000_0001);
    apb(OFS_CFG, 1'b1, 32'h0000_0002);
    apb(OFS_SWUPD, 1'b1, 32'hBEEF_1234);
    repeat (4) @(negedge CORE_CLK);
    chk({CH1_CODE, CH0_CODE}, 32'hBEEF_1234);
    apb(OFS_CFG, 1'b1, 32'h0000_0008);
    apb(OFS_COUNT, 1'b1, 32'h0000_0003);
    apb(OFS_DIV, 1'b1, 32'h0000_0002);
    slow <= 1'b1;
    for (int i = 0; i < 3; i++) host_u.q.push_back(w[i]);
    repeat (12) @(posedge CORE_CLK);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(r, 32'h0000_0300);
    apb(OFS_CTRL, 1'b1, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      wstb(n);
      chk({CH1_CODE, CH0_CODE}, w[i]);
      if (i > 0) chk(32'(n), 32'h0000_0002);
    end
    repeat (10) @(posedge CORE_CLK);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(r, 32'h0000_0012);
    apb(OFS_DONE, 1'b0, 32'h0);
    chk(r, 32'h0000_0003);
    apb(OFS_CFG, 1'b1, 32'h0000_0020);
    apb(OFS_DATA, 1'b1, 32'h4444_DDDD);
    apb(OFS_CTRL, 1'b1, 32'h0000_0001);
    repeat (20) @(posedge CORE_CLK);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(r & 32'h0000_000F, 32'h0000_000A);
    chk({CH1_CODE, CH0_CODE}, 32'h4444_DDDD);
    apb(OFS_STAT, 1'b1, 32'h0000_0008);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(r & 32'h0000_000F, 32'h0000_0002);
    apb(OFS_PINOE, 1'b1, 32'h0000_0002);
    apb(OFS_PINOE, 1'b0, 32'h0);
    chk(r, 32'h0000_0002);
    chk({16'h0000, PFP_OE}, 32'h0000_0002);
    // Queue-only replay, pin clock, start on pin 2, pause on pin 3
    apb(OFS_CFG, 1'b1, 32'h0062_0291);
    apb(OFS_DATA, 1'b1, w[0]);
    apb(OFS_DATA, 1'b1, w[1]);
    apb(OFS_CTRL, 1'b1, 32'h0000_0001);
    apb(OFS_DATA, 1'b1, 32'h5555_EEEE);
    pins <= 16'h0001;
    repeat (6) @(posedge CORE_CLK);
    pins <= 16'h0004;
    for (int i = 0; i < 3; i++) begin
      repeat (4) @(posedge CORE_CLK);
      pins <= 16'h0005;
      wstb(n);
      chk({CH1_CODE, CH0_CODE}, w[i % 2]);
      chk(32'(n), 32'h0000_0004);
      @(posedge CORE_CLK);
      pins <= 16'h0004;
    end
    repeat (2) @(posedge CORE_CLK);
    pins <= 16'h000C;
    repeat (4) @(posedge CORE_CLK);
    pins <= 16'h000D;
    repeat (8) @(posedge CORE_CLK);
    chk({CH1_CODE, CH0_CODE}, w[0]);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(r, 32'h0000_0201);
    apb(OFS_CTRL, 1'b1, 32'h0000_0002);
    apb(OFS_STAT, 1'b0, 32'h0);
    chk(r, 32'h0000_0200);
    final_report();
  end
  initial begin
    repeat (3000) @(posedge CORE_CLK);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule : testbench
`default_nettype wire
